// ===== hw/fcd_scaler.sv
`timescale 1ns/1ps
`default_nettype none
module fcd_scaler (
  fcd_if.core bus
);
  logic signed [63:0] prod;
  assign prod = bus.raw * bus.scale;
  // fixed point scale; negative factor flips sign
  assign bus.scaled = prod[fcd_pkg::SCALE_FRAC +: 32];
endmodule : fcd_scaler
`default_nettype wire

// ===== hw/fcd_top.sv
`timescale 1ns/1ps
`default_nettype none
module fcd_top (
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  input  wire logic [31:0] i_raw_distance,
  input  wire logic [31:0] i_raw_speed,
  input  wire logic [31:0] i_scale_factor,
  input  wire logic        i_continuous_speed_mode,
  input  wire logic        i_meas_valid,
  input  wire logic        i_out_oct_valid,
  input  wire logic [1:0]  i_out_oct_idx,
  input  wire logic [7:0]  i_out_oct_data,
  input  wire logic        i_out_frame_end,
  input  wire logic        i_par_oct_valid,
  input  wire logic [5:0]  i_par_oct_idx,
  input  wire logic [7:0]  i_par_oct_data,
  input  wire logic        i_par_frame_end,
  input  wire logic [2:0]  i_in_oct_idx,
  input  wire logic [5:0]  i_diag_oct_idx,
  output logic [7:0]       o_in_oct_data,
  output logic [3:0]       o_in_len,
  output logic [7:0]       o_diag_oct_data,
  output logic [31:0]      o_exchanged_output_value,
  output logic [31:0]      o_offset
);
  fcd_if sc_if ();
  fcd_scaler u_scaler (.bus(sc_if));

  logic signed [31:0] offset_reg, offset_next;
  logic signed [31:0] dist_reg, speed_reg;
  logic [31:0]        preset_reg, par_reg;
  logic [7:0]         in_oct_reg, diag_oct_reg;
  logic [3:0]         in_len_reg;
  logic signed [31:0] dist_calc;
  logic signed [31:0] preset_ofs;
  logic               preset_apply;
  logic               par_apply;

  // big-endian octet pick: index 0 is the msb octet
  function automatic logic [7:0] be_octet(input logic [31:0] w, input logic [1:0] k);
    be_octet = w[(3 - k) * 8 +: 8];
  endfunction : be_octet

  assign sc_if.raw   = i_raw_distance;
  assign sc_if.scale = i_scale_factor;
  assign dist_calc   = sc_if.scaled + offset_reg;
  assign preset_apply = i_out_frame_end && preset_reg[fcd_pkg::PRESET_FLAG_BIT];
  // flag bit excluded; the preset value is the 31-bit signed remainder
  assign preset_ofs  = {preset_reg[30], preset_reg[30:0]} - sc_if.scaled;
  assign par_apply   = i_par_frame_end;

  always_comb begin
    offset_next = offset_reg;
    if (preset_apply) begin
      offset_next = preset_ofs;
    end else if (par_apply) begin
      offset_next = par_reg;
    end
  end

  // collect master preset octets, msb first
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      preset_reg <= fcd_pkg::OFFSET_RST;
    end else if (i_out_oct_valid) begin
      preset_reg[(3 - i_out_oct_idx) * 8 +: 8] <= i_out_oct_data;
    end
  end

  logic [1:0] par_k;
  assign par_k = 2'(i_par_oct_idx - 6'(fcd_pkg::PARAM_OFS_FIRST));

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      par_reg <= fcd_pkg::OFFSET_RST;
    end else if (i_par_oct_valid && i_par_oct_idx >= 6'(fcd_pkg::PARAM_OFS_FIRST)
                 && i_par_oct_idx <= 6'(fcd_pkg::PARAM_OFS_LAST)) begin
      par_reg[(3 - par_k) * 8 +: 8] <= i_par_oct_data;
    end
  end

  // volatile offset, cleared on reset only
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      offset_reg <= fcd_pkg::OFFSET_RST;
    end else begin
      offset_reg <= offset_next;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      dist_reg  <= fcd_pkg::OFFSET_RST;
      speed_reg <= fcd_pkg::OFFSET_RST;
    end else if (i_meas_valid) begin
      dist_reg  <= dist_calc;
      speed_reg <= i_raw_speed;
    end
  end

  logic [7:0] in_sel;
  logic [1:0] in_k;
  assign in_k = i_in_oct_idx[1:0];
  assign in_sel = !i_in_oct_idx[2] ? be_octet(dist_reg, in_k) :
                  i_continuous_speed_mode ? be_octet(speed_reg, in_k) : 8'h00;

  logic [7:0] diag_sel;
  logic [1:0] diag_k;
  logic       diag_hit;
  assign diag_k = 2'(i_diag_oct_idx - 6'(fcd_pkg::DIAG_OFS_FIRST));
  assign diag_hit = i_diag_oct_idx >= 6'(fcd_pkg::DIAG_OFS_FIRST)
                    && i_diag_oct_idx <= 6'(fcd_pkg::DIAG_OFS_LAST);
  assign diag_sel = diag_hit ? be_octet(offset_reg, diag_k) : 8'h00;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      in_oct_reg   <= 8'h00;
      diag_oct_reg <= 8'h00;
      in_len_reg   <= fcd_pkg::IN_LEN_SHORT;
    end else begin
      in_oct_reg   <= in_sel;
      diag_oct_reg <= diag_sel;
      in_len_reg   <= i_continuous_speed_mode ? fcd_pkg::IN_LEN_LONG : fcd_pkg::IN_LEN_SHORT;
    end
  end

  assign o_in_oct_data            = in_oct_reg;
  assign o_in_len                 = in_len_reg;
  assign o_diag_oct_data          = diag_oct_reg;
  assign o_exchanged_output_value = dist_reg;
  assign o_offset                 = offset_reg;

  chk_offset_reset: assert property (@(posedge i_core_clk) i_srst |=> offset_reg == 32'h0000_0000)
    else $error("offset not zero after reset");
  chk_preset_apply: assert property (@(posedge i_core_clk) disable iff (i_srst)
    preset_apply |=> offset_reg == $past(preset_ofs))
    else $error("preset not applied");
  chk_offset_hold: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !i_out_frame_end && !i_par_frame_end |=> $stable(offset_reg))
    else $error("offset changed without cause");
  chk_param_write: assert property (@(posedge i_core_clk) disable iff (i_srst)
    par_apply && !preset_apply |=> offset_reg == $past(par_reg))
    else $error("parameter offset not taken");
  chk_sum_out: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_meas_valid |=> dist_reg == $past(sc_if.scaled) + $past(offset_reg))
    else $error("output not raw plus offset");
  chk_len_mode: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_continuous_speed_mode ##1 i_continuous_speed_mode |-> o_in_len == 4'h8)
    else $error("input length wrong");
  chk_msb_first: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_in_oct_idx == 3'h0 |=> o_in_oct_data == $past(dist_reg[31:24]))
    else $error("octet order wrong");
  chk_diag_offset: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_diag_oct_idx == 6'h21 |=> o_diag_oct_data == $past(offset_reg[7:0]))
    else $error("diag offset octet wrong");
  chk_preset_flag: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_out_frame_end && !preset_reg[31] && !i_par_frame_end |=> $stable(offset_reg))
    else $error("normal mode changed offset");
  chk_reset_len: assert property (@(posedge i_core_clk) i_srst |=> o_in_len == 4'h4)
    else $error("input length not short after reset");
  chk_reset_value: assert property (@(posedge i_core_clk) i_srst |=> o_exchanged_output_value == 32'h0000_0000)
    else $error("output value not zero after reset");
  chk_reset_diag: assert property (@(posedge i_core_clk) i_srst |=> o_diag_oct_data == 8'h00)
    else $error("diag octet not zero after reset");
  chk_reset_inoct: assert property (@(posedge i_core_clk) i_srst |=> o_in_oct_data == 8'h00)
    else $error("input octet not zero after reset");
  chk_len_short: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !i_continuous_speed_mode |=> o_in_len == 4'h4)
    else $error("short input length wrong");
  chk_len_long: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_continuous_speed_mode |=> o_in_len == 4'h8)
    else $error("long input length wrong");
  chk_dist_oct1: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_in_oct_idx == 3'h1 |=> o_in_oct_data == $past(dist_reg[23:16]))
    else $error("distance octet 1 wrong");
  chk_dist_oct2: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_in_oct_idx == 3'h2 |=> o_in_oct_data == $past(dist_reg[15:8]))
    else $error("distance octet 2 wrong");
  chk_dist_oct3: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_in_oct_idx == 3'h3 |=> o_in_oct_data == $past(dist_reg[7:0]))
    else $error("distance octet 3 wrong");
  chk_speed_oct4: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_continuous_speed_mode && i_in_oct_idx == 3'h4 |=> o_in_oct_data == $past(speed_reg[31:24]))
    else $error("speed octet 4 wrong");
  chk_speed_oct5: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_continuous_speed_mode && i_in_oct_idx == 3'h5 |=> o_in_oct_data == $past(speed_reg[23:16]))
    else $error("speed octet 5 wrong");
  chk_speed_oct6: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_continuous_speed_mode && i_in_oct_idx == 3'h6 |=> o_in_oct_data == $past(speed_reg[15:8]))
    else $error("speed octet 6 wrong");
  chk_speed_oct7: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_continuous_speed_mode && i_in_oct_idx == 3'h7 |=> o_in_oct_data == $past(speed_reg[7:0]))
    else $error("speed octet 7 wrong");
  chk_speed_off: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !i_continuous_speed_mode && i_in_oct_idx[2] |=> o_in_oct_data == 8'h00)
    else $error("speed octet sent in short mode");
  chk_diag_msb: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_diag_oct_idx == 6'h1e |=> o_diag_oct_data == $past(offset_reg[31:24]))
    else $error("diag offset msb wrong");
  chk_diag_oct31: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_diag_oct_idx == 6'h1f |=> o_diag_oct_data == $past(offset_reg[23:16]))
    else $error("diag offset octet 31 wrong");
  chk_diag_oct32: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_diag_oct_idx == 6'h20 |=> o_diag_oct_data == $past(offset_reg[15:8]))
    else $error("diag offset octet 32 wrong");
  chk_diag_outside: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_diag_oct_idx < 6'h1e || i_diag_oct_idx > 6'h21 |=> o_diag_oct_data == 8'h00)
    else $error("diag octet outside offset not zero");
  chk_value_hold: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !i_meas_valid |=> $stable(o_exchanged_output_value))
    else $error("output value changed without measurement");
  chk_preset_wins: assert property (@(posedge i_core_clk) disable iff (i_srst)
    preset_apply && par_apply |=> offset_reg == $past(preset_ofs))
    else $error("parameter write beat preset");
  chk_speed_latch: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_meas_valid |=> speed_reg == $past(i_raw_speed))
    else $error("speed not latched");
  chk_speed_hold: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !i_meas_valid |=> $stable(speed_reg))
    else $error("speed changed without measurement");
  chk_preset_oct0: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_out_oct_valid && i_out_oct_idx == 2'h0 |=> preset_reg[31:24] == $past(i_out_oct_data))
    else $error("preset octet 0 misplaced");
  chk_preset_oct1: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_out_oct_valid && i_out_oct_idx == 2'h1 |=> preset_reg[23:16] == $past(i_out_oct_data))
    else $error("preset octet 1 misplaced");
  chk_preset_oct2: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_out_oct_valid && i_out_oct_idx == 2'h2 |=> preset_reg[15:8] == $past(i_out_oct_data))
    else $error("preset octet 2 misplaced");
  chk_preset_oct3: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_out_oct_valid && i_out_oct_idx == 2'h3 |=> preset_reg[7:0] == $past(i_out_oct_data))
    else $error("preset octet 3 misplaced");
  chk_preset_idle: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !i_out_oct_valid |=> $stable(preset_reg))
    else $error("preset word changed while idle");
  chk_par_oct32: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_par_oct_valid && i_par_oct_idx == 6'h20 |=> par_reg[31:24] == $past(i_par_oct_data))
    else $error("parameter octet 32 misplaced");
  chk_par_oct33: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_par_oct_valid && i_par_oct_idx == 6'h21 |=> par_reg[23:16] == $past(i_par_oct_data))
    else $error("parameter octet 33 misplaced");
  chk_par_oct34: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_par_oct_valid && i_par_oct_idx == 6'h22 |=> par_reg[15:8] == $past(i_par_oct_data))
    else $error("parameter octet 34 misplaced");
  chk_par_oct35: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_par_oct_valid && i_par_oct_idx == 6'h23 |=> par_reg[7:0] == $past(i_par_oct_data))
    else $error("parameter octet 35 misplaced");
  chk_par_ignore: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_par_oct_valid && (i_par_oct_idx < 6'h20 || i_par_oct_idx > 6'h23) |=> $stable(par_reg))
    else $error("foreign parameter octet taken");
  chk_par_idle: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !i_par_oct_valid |=> $stable(par_reg))
    else $error("parameter word changed while idle");
  chk_scale_unity: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_scale_factor == 32'h0001_0000 |-> sc_if.scaled == i_raw_distance)
    else $error("unity scale changed value");
  chk_scale_negate: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_scale_factor == 32'hffff_0000 |-> sc_if.scaled == -i_raw_distance)
    else $error("negative scale did not invert sign");
endmodule : fcd_top
`default_nettype wire

// ===== pkg/fcd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fcd_if;
  logic signed [31:0] raw;
  logic signed [31:0] scale;
  logic signed [31:0] scaled;
  modport core (input raw, input scale, output scaled);
  modport user (output raw, output scale, input scaled);
endinterface : fcd_if
`default_nettype wire

// ===== pkg/fcd_pkg.sv
`default_nettype none
package fcd_pkg;
  localparam int DATA_W = 32;
  localparam int OCT_W = 8;
  localparam int IN_OCTETS = 8;
  localparam int OUT_OCTETS = 4;
  localparam int PRESET_FLAG_BIT = 31;
  localparam int PARAM_OFS_FIRST = 32;
  localparam int PARAM_OFS_LAST = 35;
  localparam int DIAG_OFS_FIRST = 30;
  localparam int DIAG_OFS_LAST = 33;
  localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
  localparam logic [3:0] IN_LEN_SHORT = 4'h4;
  localparam logic [3:0] IN_LEN_LONG = 4'h8;
  localparam int SCALE_FRAC = 16;
  localparam logic signed [31:0] SCALE_RST = 32'h0001_0000;
endpackage : fcd_pkg
`default_nettype wire

// ===== tb/fcd_master.sv
`timescale 1ns/1ps
`default_nettype none
module fcd_master (
  input  wire logic       i_core_clk,
  output logic            o_oct_valid,
  output logic [5:0]      o_oct_idx,
  output logic [7:0]      o_oct_data,
  output logic            o_frame_end
);
  initial begin
    o_oct_valid = 1'b0;
    o_oct_idx   = 6'h3f;
    o_oct_data  = 8'h00;
    o_frame_end = 1'b0;
  end
  // octets go msb first, frame_end closes the word
  task automatic send(input logic [5:0] base, input logic [31:0] word);
    for (int i = 0; i < 4; i++) begin
      @(posedge i_core_clk) #1;
      o_oct_valid = 1'b1;
      o_oct_idx   = base + 6'(i);
      o_oct_data  = word[31-8*i -: 8];
    end
    @(posedge i_core_clk) #1;
    o_oct_valid = 1'b0;
    o_oct_data  = ~o_oct_data; // released data no longer shows the last octet
    o_frame_end = 1'b1;
    @(posedge i_core_clk) #1;
    o_frame_end = 1'b0;
  endtask : send
endmodule : fcd_master
`default_nettype wire

// ===== tb/fieldbus_cyclic_distance_preset_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fieldbus_cyclic_distance_preset_tb;
  logic clk, srst, mode, mv, pv, pfe, ov, ofe;
  logic [31:0] raw, spd, sf, exp_v, ofs, o_xv, o_ofs;
  logic [5:0] pidx, oidx, didx;
  logic [7:0] pd, od, o_in, o_dg;
  logic [2:0] iidx;
  logic [3:0] o_len;
  int fail_count, checked, seed;
  logic [31:0] sft [4] = '{32'h0001_0000, 32'hffff_0000, 32'h0000_8000, 32'h0002_4000};
  fcd_top u_fcd_top (.i_core_clk(clk), .i_srst(srst), .i_raw_distance(raw), .i_raw_speed(spd),
    .i_scale_factor(sf), .i_continuous_speed_mode(mode), .i_meas_valid(mv), .i_out_oct_valid(ov),
    .i_out_oct_idx(oidx[1:0]), .i_out_oct_data(od), .i_out_frame_end(ofe), .i_par_oct_valid(pv),
    .i_par_oct_idx(pidx), .i_par_oct_data(pd), .i_par_frame_end(pfe), .i_in_oct_idx(iidx),
    .i_diag_oct_idx(didx), .o_in_oct_data(o_in), .o_in_len(o_len), .o_diag_oct_data(o_dg),
    .o_exchanged_output_value(o_xv), .o_offset(o_ofs));
  fcd_master u_pre (.i_core_clk(clk), .o_oct_valid(ov), .o_oct_idx(oidx), .o_oct_data(od), .o_frame_end(ofe));
  fcd_master u_par (.i_core_clk(clk), .o_oct_valid(pv), .o_oct_idx(pidx), .o_oct_data(pd), .o_frame_end(pfe));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // q16.16 product, truncated toward minus infinity
  function automatic logic [31:0] scl(input logic [31:0] r, input logic [31:0] s);
    longint p;
    p = longint'($signed(r)) * longint'($signed(s));
    return 32'(p >>> 16);
  endfunction : scl
  task automatic meas;
    @(posedge clk) #1 mv = 1'b1;
    @(posedge clk) #1 mv = 1'b0;
    exp_v = scl(raw, sf) + ofs;
    chk("value", o_xv, exp_v);
  endtask : meas
  task automatic rd(input logic [2:0] i, input logic [5:0] d);
    @(posedge clk) #1 iidx = i;
    didx = d;
    @(posedge clk) #1;
  endtask : rd
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  initial begin
    {srst, mode, mv, iidx, didx, ofs} = '0;
    srst = 1'b1;
    seed = 43;
    raw = 32'h0000_0000;
    spd = 32'h0000_0000;
    sf = 32'h0001_0000;
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    chk("rst_ofs", o_ofs, 32'h0000_0000);
    chk("rst_len", 32'(o_len), 32'h0000_0004);
    chk("rst_val", o_xv, 32'h0000_0000);
    chk("rst_in", 32'(o_in), 32'h0000_0000);
    chk("rst_dg", 32'(o_dg), 32'h0000_0000);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      raw = $random(seed);
      spd = $random(seed);
      sf = sft[k%4];
      mode = k[0];
      meas();
      chk("len", 32'(o_len), mode ? 32'h0000_0008 : 32'h0000_0004);
      for (int i = 0; i < 8; i++) begin
        rd(3'(i), 6'h00);
        chk("in_oct", 32'(o_in), 32'({exp_v, mode ? spd : 32'h0000_0000} >> (56-8*i)) & 32'hff);
      end
    end
    $display("test stream done");
    foreach (sft[j]) begin
      raw = $random(seed) >>> 4;
      sf = sft[j];
      u_pre.send(6'h00, {j[0], 31'h1234_5678 ^ 31'(j << 29)});
      if (j[0]) ofs = {sft[0][31], 31'h1234_5678 ^ 31'(j << 29)};
      if (j[0]) ofs = {ofs[30], ofs[30:0]} - scl(raw, sf);
      chk("pre_ofs", o_ofs, ofs);
      meas();
      for (int d = 29; d < 35; d++) begin
        rd(3'h0, 6'(d));
        chk("diag", 32'(o_dg), (d < 30 || d > 33) ? 32'h0 : 32'(ofs >> (8*(33-d))) & 32'hff);
      end
    end
    $display("test preset done");
    ofs = $random(seed);
    u_par.send(6'h20, ofs);
    u_par.send(6'h1c, ~ofs);
    chk("par_ofs", o_ofs, ofs);
    meas();
    $display("test param done");
    raw = $random(seed);
    sf = sft[1];
    exp_v = $random(seed);
    fork
      u_pre.send(6'h00, {1'b1, exp_v[30:0]});
      u_par.send(6'h20, ~exp_v);
    join
    ofs = {exp_v[30], exp_v[30:0]} - scl(raw, sf);
    chk("both_ofs", o_ofs, ofs);
    fork
      u_pre.send(6'h00, {1'b0, exp_v[30:0]});
      u_par.send(6'h20, exp_v);
    join
    ofs = exp_v;
    chk("par_wins", o_ofs, ofs);
    meas();
    $display("test order done");
    @(posedge clk) #1 srst = 1'b1;
    @(posedge clk) #1 srst = 1'b0;
    ofs = 32'h0000_0000;
    chk("mid_ofs", o_ofs, ofs);
    chk("mid_len", 32'(o_len), 32'h0000_0004);
    meas();
    $display("test reset again done");
    wrap_up();
  end
endmodule : fieldbus_cyclic_distance_preset_tb
`default_nettype wire
